// File: pfig_pkg.sv
// pfig_pkg.sv: shared constants and types of the fault supervision and interrupt block.
// Assumes one 125 MHz digital clock and a 32-bit AHB-Lite register bus.
package pfig_pkg;

   // ****************************************
   // timing and counts
   // ****************************************
   localparam int CLK_MHZ = 125;
   localparam int LIMIT_TIME_US = 20;
   localparam int LIMIT_CYC = LIMIT_TIME_US * CLK_MHZ;
   localparam int OVERLOAD_TIME_MS = 1;
   localparam int OVERLOAD_CYC = OVERLOAD_TIME_MS * 1000 * CLK_MHZ;
   localparam int NUM_BUCK = 2;
   localparam int NUM_LDO = 2;
   localparam int NUM_REG = NUM_BUCK + NUM_LDO;
   localparam int NUM_GPO = 2;

   // ****************************************
   // register byte addresses
   // ****************************************
   localparam logic [7:0] A_BUCK_CTRL = 8'h00;
   localparam logic [7:0] A_LDO_CTRL = 8'h04;
   localparam logic [7:0] A_CONFIG = 8'h08;
   localparam logic [7:0] A_GPO_CTRL = 8'h0c;
   localparam logic [7:0] A_FLAGS = 8'h10;
   localparam logic [7:0] A_MASK = 8'h14;
   localparam logic [7:0] A_STAT = 8'h18;
   localparam logic [7:0] A_RESET = 8'h1c;

   // buck ctrl: per buck byte n: [0] enable, [1] discharge enable, [4:2] peak limit
   localparam int BK_STRIDE = 8;
   localparam int BK_EN = 0;
   localparam int BK_DIS = 1;
   localparam int BK_LIM_LO = 2;
   localparam int LIM_W = 3;
   // ldo ctrl: per ldo byte n: [0] enable, [1] discharge enable
   // config: [0] hot warning threshold select, [1] shared pin function select
   localparam int CF_HOT = 0;
   localparam int CF_PIN = 1;
   // gpo ctrl per byte n: [0] drive type (1 open drain), [1] level, [2] sequence ctrl
   localparam int GP_OD = 0;
   localparam int GP_LVL = 1;
   localparam int GP_SEQ = 2;
   // flags / mask bit positions
   localparam int F_BLIM = 0;   // 2 bits
   localparam int F_LLIM = 2;   // 2 bits
   localparam int F_BSC = 4;    // 2 bits
   localparam int F_LSC = 6;    // 2 bits
   localparam int F_BSUM = 8;   // 2 bits
   localparam int F_LSUM = 10;  // 2 bits
   localparam int F_HOT = 12;
   localparam int F_OVP = 13;
   localparam int F_TSD = 14;
   localparam int F_RST = 15;
   localparam int FLAG_W = 16;
   // stat: [1:0] buck limit live, [3:2] ldo limit live, [4] hot, [5] ovp, [6] tsd,
   // [8:7] buck on, [10:9] ldo on, [12:11] mode
   localparam int S_ON = 7;
   localparam int S_MODE = 11;
   localparam logic [FLAG_W-1:0] MASK_RST = 16'h0000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [1:0] {PFIG_SHUTDOWN, PFIG_STANDBY, PFIG_ACTIVE} pfig_mode_t;

   typedef struct packed {
      logic [NUM_BUCK-1:0] buck_limit;
      logic [NUM_LDO-1:0] ldo_limit;
      logic [NUM_REG-1:0] below_short;   // buck0,buck1,ldo0,ldo1
      logic hot_warn;
      logic hot_warn_alt;
      logic overvoltage;
      logic overheat;
   } pfig_analog_t;

   typedef struct packed {
      logic [NUM_REG-1:0] power_stage_on;
      logic [NUM_REG-1:0] discharge_on;
   } pfig_reg_drive_t;

   typedef struct packed {
      logic [NUM_GPO-1:0] out;
      logic [NUM_GPO-1:0] oe_n;
      logic shared_pin_is_clock;
   } pfig_gpo_t;

endpackage

// File: pfig_persist.sv
// pfig_persist.sv: counts how long a level has held and reports once it has held long enough.
// Assumes its input is already synchronous to hclk.
`timescale 1ns/10ps
`default_nettype none
module pfig_persist #(
   parameter int CYCLES = 2500
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic level,
   output logic held
);
   import pfig_pkg::*;

   typedef struct packed {
      logic [$clog2(CYCLES+1)-1:0] cnt;
      logic held;
   } pfig_cnt_t;

   pfig_cnt_t s_r;
   pfig_cnt_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      if (!level)
      begin
         s_nxt.cnt = '0;
         s_nxt.held = 1'b0;
      end
      else if (s_r.cnt == ($clog2(CYCLES+1))'(CYCLES - 1))
      begin
         s_nxt.held = 1'b1;
      end
      else
      begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign held = s_r.held;
endmodule
`default_nettype wire

// File: pfig_fault_irq.sv
// pfig_fault_irq.sv: fault supervision, sticky flags, interrupt pin and aux outputs.
// Assumes analog indications arrive asynchronously; hresetn is the supply lockout reset.
//
// Behaviour
// - buck limit held 20us sets flag, irq
// - each buck has 3-bit peak limit
// - live buck limit bit; write-1 clears flag
// - buck limit mask blocks its interrupt
// - ldo limit 20us: flag, live, w1c, mask
// - hot warning: threshold select, flag, mask
// - fault disable: stage off, discharge if enabled
// - below short threshold 1ms after enable
// - below overload threshold 1ms disables regulator
// - buck short: flags, status cleared, irq
// - ldo short: flags, status cleared, irq
// - clearing short flag restarts enabled regulator
// - overvoltage watched in standby/active only
// - overvoltage: all off, gpo low, flag
// - overvoltage flag sticks while input high
// - no enable while overvoltage or pending
// - thermal shutdown: all off, flag, standby
// - shutdown flag sticks while hot; no enable
// - lockout disables all; recovery enters standby
// - reset flag set after shutdown or reset
// - shared pin: aux output or clock input
// - aux drive type, level, sequence control
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module pfig_fault_irq #(
   parameter int OVERLOAD_CYCLES = pfig_pkg::OVERLOAD_CYC,
   parameter int LIMIT_CYCLES = pfig_pkg::LIMIT_CYC
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire pfig_pkg::pfig_analog_t analog_in,
   input wire logic enable_pin,
   output pfig_pkg::pfig_reg_drive_t reg_drive,
   output pfig_pkg::pfig_gpo_t gpo,
   output logic [pfig_pkg::NUM_BUCK*pfig_pkg::LIM_W-1:0] buck_peak_limit_sel,
   output logic hot_warn_threshold_sel,
   output logic irq_out_n
);
   import pfig_pkg::*;

   typedef struct packed {
      pfig_analog_t s1;
      pfig_analog_t s2;
      pfig_analog_t s3;
      logic [2:0] en_sync;
      logic [31:0] buck_ctrl;
      logic [31:0] ldo_ctrl;
      logic [1:0] config_bits;
      logic [31:0] gpo_ctrl;
      logic [FLAG_W-1:0] flags;
      logic [FLAG_W-1:0] mask;
      logic [NUM_REG-1:0] on_status;
      logic [NUM_REG-1:0] starting;
      pfig_mode_t mode;
      logic wr_pend;
      logic rd_pend;
      logic [7:0] addr;
      logic [31:0] rdata;
      pfig_reg_drive_t drive;
      pfig_gpo_t gpo;
      logic irq_n;
   } pfig_state_t;

   pfig_state_t s_r;
   pfig_state_t s_nxt;
   pfig_analog_t live;
   logic [NUM_REG-1:0] low_held;
   logic [NUM_BUCK-1:0] blim_held;
   logic [NUM_LDO-1:0] llim_held;
   logic [NUM_REG-1:0] reg_en;
   logic [NUM_REG-1:0] dis_en;

   // ****************************************
   // input filter: live always follows stage 3, whether or not stages 2 and 3 agree
   // ****************************************
   always_comb
   begin
      live = s_r.s3;
      for (int i = 0; i < $bits(pfig_analog_t); i++)
      begin
         if (s_r.s2[i] == s_r.s3[i])
            live[i] = s_r.s2[i];
      end
   end

   // ****************************************
   // persistence timers
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < NUM_REG; g++)
      begin : g_reg
         pfig_persist #(.CYCLES(OVERLOAD_CYCLES)) u_low (
            .hclk(hclk),
            .hresetn(hresetn),
            .level(live.below_short[g] & s_r.on_status[g]),
            .held(low_held[g])
         );
         if (g < NUM_BUCK)
         begin : g_bk
            assign reg_en[g] = s_r.buck_ctrl[g*BK_STRIDE+BK_EN];
            assign dis_en[g] = s_r.buck_ctrl[g*BK_STRIDE+BK_DIS];
            assign buck_peak_limit_sel[g*LIM_W +: LIM_W] =
               s_r.buck_ctrl[g*BK_STRIDE+BK_LIM_LO +: LIM_W];
            pfig_persist #(.CYCLES(LIMIT_CYCLES)) u_lim (
               .hclk(hclk),
               .hresetn(hresetn),
               .level(live.buck_limit[g]),
               .held(blim_held[g])
            );
         end
         else
         begin : g_ld
            assign reg_en[g] = s_r.ldo_ctrl[(g-NUM_BUCK)*BK_STRIDE+BK_EN];
            assign dis_en[g] = s_r.ldo_ctrl[(g-NUM_BUCK)*BK_STRIDE+BK_DIS];
            pfig_persist #(.CYCLES(LIMIT_CYCLES)) u_lim (
               .hclk(hclk),
               .hresetn(hresetn),
               .level(live.ldo_limit[g-NUM_BUCK]),
               .held(llim_held[g-NUM_BUCK])
            );
         end
      end
   endgenerate

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      logic [FLAG_W-1:0] w1c;
      logic [FLAG_W-1:0] setv;
      logic ovp_ev;
      logic tsd_ev;
      logic block_en;
      logic [NUM_REG-1:0] sc_ev;
      logic [NUM_REG-1:0] sc_flag;
      logic hot_now;
      w1c = '0;
      setv = '0;
      ovp_ev = 1'b0;
      tsd_ev = 1'b0;
      block_en = 1'b0;
      sc_ev = '0;
      sc_flag = '0;
      hot_now = 1'b0;
      s_nxt = s_r;
      s_nxt.s1 = analog_in;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      s_nxt.en_sync = {s_r.en_sync[1:0], enable_pin};
      s_nxt.rd_pend = 1'b0;
      s_nxt.wr_pend = 1'b0;

      // bus: address phase latched, data phase writes
      if (hsel && hready && htrans == HTRANS_NONSEQ)
      begin
         s_nxt.addr = haddr[7:0];
         s_nxt.wr_pend = hwrite;
         s_nxt.rd_pend = !hwrite;
      end
      if (s_r.wr_pend)
      begin
         unique case (s_r.addr)
            A_BUCK_CTRL: s_nxt.buck_ctrl = hwdata;
            A_LDO_CTRL: s_nxt.ldo_ctrl = hwdata;
            A_CONFIG: s_nxt.config_bits = hwdata[1:0];
            A_GPO_CTRL: s_nxt.gpo_ctrl = hwdata;
            A_FLAGS: w1c = hwdata[FLAG_W-1:0];
            A_MASK: s_nxt.mask = hwdata[FLAG_W-1:0];
            default: ;
         endcase
      end

      // overvoltage only watched when powered up
      ovp_ev = live.overvoltage && s_r.mode != PFIG_SHUTDOWN;
      tsd_ev = live.overheat;
      hot_now = s_r.config_bits[CF_HOT] ? live.hot_warn_alt : live.hot_warn;
      sc_ev = low_held;

      setv[F_BLIM +: NUM_BUCK] = blim_held;
      setv[F_LLIM +: NUM_LDO] = llim_held;
      setv[F_BSC +: NUM_BUCK] = sc_ev[NUM_BUCK-1:0];
      setv[F_BSUM +: NUM_BUCK] = sc_ev[NUM_BUCK-1:0];
      setv[F_LSC +: NUM_LDO] = sc_ev[NUM_REG-1:NUM_BUCK];
      setv[F_LSUM +: NUM_LDO] = sc_ev[NUM_REG-1:NUM_BUCK];
      setv[F_HOT] = hot_now;
      setv[F_OVP] = ovp_ev;
      setv[F_TSD] = tsd_ev;
      // set wins over a clear in the same cycle
      s_nxt.flags = (s_r.flags & ~w1c) | setv;

      sc_flag = {s_r.flags[F_LSC +: NUM_LDO], s_r.flags[F_BSC +: NUM_BUCK]};
      block_en = live.overvoltage || s_r.flags[F_OVP]
               || live.overheat || s_r.flags[F_TSD];

      // a regulator starts once enabled and its flags allow, and stays on until a fault or its enable bit clears
      for (int i = 0; i < NUM_REG; i++)
      begin
         if (!reg_en[i] || block_en || sc_flag[i] || sc_ev[i] || ovp_ev || tsd_ev)
            s_nxt.on_status[i] = 1'b0;
         else
            s_nxt.on_status[i] = 1'b1;
         s_nxt.drive.power_stage_on[i] = s_nxt.on_status[i];
         s_nxt.drive.discharge_on[i] = !s_nxt.on_status[i] && dis_en[i];
      end

      if (s_r.mode == PFIG_SHUTDOWN)
         s_nxt.mode = PFIG_STANDBY;
      else if (tsd_ev || s_nxt.on_status == '0)
         s_nxt.mode = PFIG_STANDBY;
      else
         s_nxt.mode = PFIG_ACTIVE;

      // aux outputs; sequence-controlled ones follow the enable pin
      for (int k = 0; k < NUM_GPO; k++)
      begin
         logic lvl;
         lvl = s_r.gpo_ctrl[k*BK_STRIDE+GP_SEQ] ? s_r.en_sync[2]
             : s_r.gpo_ctrl[k*BK_STRIDE+GP_LVL];
         if (ovp_ev || s_r.flags[F_OVP])
            lvl = 1'b0;
         if (s_r.gpo_ctrl[k*BK_STRIDE+GP_OD])
         begin
            s_nxt.gpo.out[k] = 1'b0;
            s_nxt.gpo.oe_n[k] = lvl;
         end
         else
         begin
            s_nxt.gpo.out[k] = lvl;
            s_nxt.gpo.oe_n[k] = 1'b0;
         end
      end
      s_nxt.gpo.shared_pin_is_clock = s_r.config_bits[CF_PIN];
      if (s_r.config_bits[CF_PIN])
         s_nxt.gpo.oe_n[1] = 1'b1;

      // interrupt stays low while any unmasked flag is pending
      s_nxt.irq_n = ~|(s_nxt.flags & ~s_r.mask);

      s_nxt.rdata = '0;
      if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite)
      begin
         unique case (haddr[7:0])
            A_BUCK_CTRL: s_nxt.rdata = s_r.buck_ctrl;
            A_LDO_CTRL: s_nxt.rdata = s_r.ldo_ctrl;
            A_CONFIG: s_nxt.rdata = {30'h0, s_r.config_bits};
            A_GPO_CTRL: s_nxt.rdata = s_r.gpo_ctrl;
            A_FLAGS: s_nxt.rdata = {16'h0, s_r.flags};
            A_MASK: s_nxt.rdata = {16'h0, s_r.mask};
            A_STAT: s_nxt.rdata = {19'h0, 2'(s_r.mode), s_r.on_status, live.overheat,
                                   live.overvoltage, hot_now, live.ldo_limit,
                                   live.buck_limit};
            default: s_nxt.rdata = '0;
         endcase
      end

      // software reset restores defaults and flags the event
      if (s_r.wr_pend && s_r.addr == A_RESET && hwdata[0])
      begin
         s_nxt.buck_ctrl = '0;
         s_nxt.ldo_ctrl = '0;
         s_nxt.config_bits = '0;
         s_nxt.gpo_ctrl = '0;
         s_nxt.mask = MASK_RST;
         s_nxt.flags = '0;
         s_nxt.flags[F_RST] = 1'b1;
         s_nxt.on_status = '0;
         s_nxt.drive.power_stage_on = '0;
         s_nxt.mode = PFIG_STANDBY;
      end
   end

   // ****************************************
   // registers; lockout reset forces shutdown and sets the reset flag
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_r <= '0;
         s_r.flags[F_RST] <= 1'b1;
         s_r.mask <= MASK_RST;
         s_r.mode <= PFIG_SHUTDOWN;
         s_r.irq_n <= 1'b1;
         s_r.gpo.oe_n <= '1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign hrdata = s_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign reg_drive = s_r.drive;
   assign gpo = s_r.gpo;
   assign hot_warn_threshold_sel = s_r.config_bits[CF_HOT];
   assign irq_out_n = s_r.irq_n;
endmodule
`default_nettype wire

// File: pfig_fault_irq_assertions.sv
// pfig_fault_irq_assertions.sv: port checks of the fault supervision block.
// Assumes it is bound to pfig_fault_irq; one clock, hresetn resets.
`timescale 1ns/10ps
`default_nettype none
module pfig_fault_irq_assertions #(
   parameter int OVERLOAD_CYCLES = 20,
   parameter int LIMIT_CYCLES = 8
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire pfig_pkg::pfig_analog_t analog_in,
   input wire logic enable_pin,
   input wire pfig_pkg::pfig_reg_drive_t reg_drive,
   input wire pfig_pkg::pfig_gpo_t gpo,
   input wire logic [5:0] buck_peak_limit_sel,
   input wire logic hot_warn_threshold_sel,
   input wire logic irq_out_n
);
   import pfig_pkg::*;
   logic wr_take;
   logic [15:0] low_cnt_r;
   logic [15:0] low_cnt_nxt;
   assign wr_take = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
   // ***
   // low output while powered, counted in cycles
   // ***
   always_comb
   begin
      low_cnt_nxt = '0;
      if (analog_in.below_short[0] && reg_drive.power_stage_on[0])
         low_cnt_nxt = low_cnt_r + 16'h1;
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         low_cnt_r <= '0;
      else
         low_cnt_r <= low_cnt_nxt;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ***
   // assertions and covers
   // ***
   ovp_stage_off_a: assert property (
      analog_in.overvoltage [*4] |-> ##[0:3] reg_drive.power_stage_on == '0)
      else $error("regulator on during overvoltage");
   ovp_gpo_low_a: assert property (
      analog_in.overvoltage [*4] |-> ##[0:3] gpo.out == '0)
      else $error("aux output high during overvoltage");
   heat_stage_off_a: assert property (
      analog_in.overheat [*4] |-> ##[0:3] reg_drive.power_stage_on == '0)
      else $error("regulator on during overheat");
   discharge_idle_a: assert property (
      (reg_drive.discharge_on & reg_drive.power_stage_on) == '0)
      else $error("discharge while stage on");
   reset_irq_a: assert property (
      $rose(hresetn) |-> ##[0:2] !irq_out_n)
      else $error("no interrupt after reset");
   limit_sel_write_a: assert property (
      (wr_take && haddr[7:0] == A_BUCK_CTRL) ##1 1'b1 |=>
      buck_peak_limit_sel == {$past(hwdata[12:10]), $past(hwdata[4:2])})
      else $error("peak limit not taken from write");
   hot_sel_write_a: assert property (
      (wr_take && haddr[7:0] == A_CONFIG) ##1 1'b1 |=>
      hot_warn_threshold_sel == $past(hwdata[0]))
      else $error("threshold select not taken from write");
   short_stage_off_a: assert property (
      low_cnt_r <= 16'(OVERLOAD_CYCLES + 10))
      else $error("regulator kept on with low output");
   cover property ($fell(irq_out_n));
   cover property (low_cnt_r == 16'(OVERLOAD_CYCLES));
   cover property (analog_in.overheat [*4]);
endmodule
`default_nettype wire

// File: pfig_host_mon.sv
// pfig_host_mon.sv: host side watcher of the interrupt pin.
// Assumes irq_out_n is synchronous to hclk.
`timescale 1ns/10ps
`default_nettype none
module pfig_host_mon
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic irq_out_n,
   output logic [7:0] irq_events
);
   logic last_r;
   // counts falling edges, as a host would take interrupts
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         last_r <= 1'b1;
         irq_events <= 8'h00;
      end
      else
      begin
         last_r <= irq_out_n;
         if (last_r && !irq_out_n)
            irq_events <= irq_events + 8'h01;
      end
   end
endmodule
`default_nettype wire

// File: pfig_fault_irq_tb.sv
// pfig_fault_irq_tb.sv: self-checking bench of the fault and interrupt block.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module pfig_fault_irq_tb;
   import pfig_pkg::*;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [11:0] an;
   logic enable_pin;
   pfig_reg_drive_t reg_drive;
   pfig_gpo_t gpo;
   logic [5:0] lim_sel;
   logic hot_sel;
   logic irq_out_n;
   logic [7:0] irq_events;
   logic [31:0] r;
   int err_count;
   int check_count;
   int cause_bit[5] = '{10, 11, 8, 9, 3};
   int flag_bit[5] = '{0, 1, 2, 3, 12};
   int live_bit[5] = '{0, 1, 2, 3, 4};
   pfig_fault_irq #(.OVERLOAD_CYCLES(20), .LIMIT_CYCLES(8)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .analog_in(pfig_analog_t'(an)), .enable_pin(enable_pin),
      .reg_drive(reg_drive), .gpo(gpo), .buck_peak_limit_sel(lim_sel),
      .hot_warn_threshold_sel(hot_sel), .irq_out_n(irq_out_n));
   pfig_host_mon host (.hclk(hclk), .hresetn(hresetn), .irq_out_n(irq_out_n),
      .irq_events(irq_events));
   // ***
   // bus and check tasks
   // ***
   task automatic summarize;
      if (err_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic step(inout int n);
      n++;
      if (n > 100)
      begin
         err_count++;
         summarize;
      end
      @(posedge hclk);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         step(n);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         step(n);
      r = hrdata;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(nm, r & m, exp);
      chk("okay response", hresp, 32'h0);
   endtask
   initial
   begin
      hclk = 1'b0;
      forever
         #4 hclk = ~hclk;
   end
   // ***
   // main sequence
   // ***
   initial
   begin
      logic [7:0] e;
      {hresetn, hsel, haddr, htrans, hwrite, hwdata, an, enable_pin} = '0;
      hsize = 3'h2;
      err_count = 0;
      check_count = 0;
      wt(5);
      hresetn <= 1'b1;
      wt(4);
      chk("irq after reset", irq_out_n, 32'h0);
      rdchk("reset flags", A_FLAGS, 32'hffff, 32'h8000);
      bus(1'b1, A_FLAGS, 32'h8000);
      wt(3);
      chk("irq released", irq_out_n, 32'h1);
      rdchk("unmapped", 8'h20, 32'hffffffff, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         e = irq_events;
         an[cause_bit[i]] <= 1'b1;
         wt(5);
         if (i < 4)
            rdchk("early flag", A_FLAGS, 32'hffff, 32'h0);
         wt(20);
         rdchk("event flag", A_FLAGS, 32'hffff, 32'h1 << flag_bit[i]);
         rdchk("live bit", A_STAT, 32'h1 << live_bit[i], 32'h1 << live_bit[i]);
         chk("irq event", irq_events, e + 8'h1);
         bus(1'b1, A_FLAGS, 32'h1 << flag_bit[i]);
         rdchk("flag sticks", A_FLAGS, 32'hffff, 32'h1 << flag_bit[i]);
         bus(1'b1, A_MASK, 32'h1 << flag_bit[i]);
         wt(3);
         chk("masked irq", irq_out_n, 32'h1);
         an[cause_bit[i]] <= 1'b0;
         wt(10);
         bus(1'b1, A_FLAGS, 32'h1 << flag_bit[i]);
         rdchk("cleared", A_FLAGS, 32'hffff, 32'h0);
         bus(1'b1, A_MASK, 32'h0);
      end
      bus(1'b1, A_CONFIG, 32'h3);
      an[2] <= 1'b1;
      wt(10);
      chk("hot select", hot_sel, 32'h1);
      chk("pin is clock", gpo.shared_pin_is_clock, 32'h1);
      rdchk("alt hot flag", A_FLAGS, 32'h1000, 32'h1000);
      an[2] <= 1'b0;
      wt(5);
      bus(1'b1, A_FLAGS, 32'h1000);
      bus(1'b1, A_CONFIG, 32'h0);
      bus(1'b1, A_GPO_CTRL, 32'h3);
      wt(3);
      chk("open drain off", {gpo.out[0], gpo.oe_n[0]}, 32'h1);
      bus(1'b1, A_GPO_CTRL, 32'h4);
      enable_pin <= 1'b1;
      wt(8);
      chk("sequence level", gpo.out[0], 32'h1);
      enable_pin <= 1'b0;
      wt(8);
      chk("sequence low", gpo.out[0], 32'h0);
      bus(1'b1, A_GPO_CTRL, 32'h2);
      bus(1'b1, A_BUCK_CTRL, 32'h0c13);
      wt(5);
      chk("peak limit", lim_sel, 32'h1c);
      chk("gpo level", gpo.out[0], 32'h1);
      chk("stage on", reg_drive, 32'h10);
      an[4] <= 1'b1;
      wt(40);
      chk("short drive", reg_drive, 32'h01);
      rdchk("short flags", A_FLAGS, 32'hffff, 32'h110);
      rdchk("on status", A_STAT, 32'h80, 32'h0);
      an[4] <= 1'b0;
      wt(5);
      bus(1'b1, A_FLAGS, 32'h110);
      wt(5);
      chk("restart", reg_drive, 32'h10);
      for (int k = 0; k < 2; k++)
      begin
         an[1 - k] <= 1'b1;
         wt(10);
         chk("fault off", reg_drive.power_stage_on, 32'h0);
         if (k == 0)
            chk("gpo low", gpo.out, 32'h0);
         else
            rdchk("standby", A_STAT, 32'h1800, 32'h0800);
         bus(1'b1, A_FLAGS, 32'h2000 << k);
         rdchk("flag held", A_FLAGS, 32'hffff, 32'h2000 << k);
         an[1 - k] <= 1'b0;
         wt(30);
         chk("pending blocks", reg_drive.power_stage_on, 32'h0);
         bus(1'b1, A_FLAGS, 32'h2000 << k);
         wt(5);
         chk("re-enabled", reg_drive.power_stage_on, 32'h1);
      end
      bus(1'b1, A_RESET, 32'h1);
      wt(3);
      rdchk("soft reset flags", A_FLAGS, 32'hffff, 32'h8000);
      chk("soft reset drive", reg_drive, 32'h0);
      summarize;
   end
endmodule
bind pfig_fault_irq pfig_fault_irq_assertions #(.OVERLOAD_CYCLES(OVERLOAD_CYCLES),
   .LIMIT_CYCLES(LIMIT_CYCLES)) chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .analog_in(analog_in), .enable_pin(enable_pin), .reg_drive(reg_drive), .gpo(gpo),
   .buck_peak_limit_sel(buck_peak_limit_sel),
   .hot_warn_threshold_sel(hot_warn_threshold_sel), .irq_out_n(irq_out_n));
`default_nettype wire
